/* File: rtl/fsk_flash_security.sv */
// Flash security unlock, protection and clock setup control
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "fsk_cfg.svh"

// How it works
// - Closing the key window with a matching key unsecures until reset.
// - Key bytes are accepted only from code running out of RAM.
// - Flash array reads are blocked while the key window is open.
// - The stored key sits in the vector block and shares its protection.
// - Application code cannot change protection, security or key in protected block.
// - Protection register accepts writes only from background debug.
// - Blank check on unprotected, erased flash unsecures until reset.
// - Security state loads from the option byte at reset.
// - Seven byte registers; three are copied from flash at reset.
// - Divider top bit is read-only status; low bits write once.
// - Erase and program are refused until the divider is written.
module fsk_flash_security (
    // Clock and reset
    input  wire logic                    CLK,
    input  wire logic                    RESET_N,
    // Register port
    input  wire logic [`FSK_ADDR_W-1:0]  ADDR,
    input  wire logic [7:0]              WDATA,
    input  wire logic                    WR,
    input  wire logic                    RD,
    output logic [7:0]                   RDATA,
    // Access source qualifiers
    input  wire logic                    DBG_ACCESS,
    input  wire logic                    RAM_EXEC,
    // Nonvolatile contents
    input  wire logic [7:0]              NV_OPTION,
    input  wire logic [7:0]              NV_PROTECT,
    input  wire logic [7:0]              NV_TRIM,
    input  wire logic [63:0]             NV_KEY,
    // Flash engine
    input  wire logic                    VEC_TARGET,
    input  wire logic                    FLASH_DONE,
    input  wire logic                    FLASH_BLANK,
    output logic                         CMD_START,
    output logic [7:0]                   CMD_CODE,
    output logic [6:0]                   DIV_VALUE,
    // Security state
    output logic                         SECURED,
    output logic                         ARRAY_RD_BLOCK
);

    fsk_pkg::fsk_state_t st;
    fsk_pkg::fsk_state_t next_st;

    logic       key_match;
    logic [3:0] key_count;
    logic       key_wr;
    logic       key_clr;
    logic       div_wr;
    logic [7:0] div_reg;
    logic       div_done;
    logic       run;
    logic       is_key;
    logic       win;

    // ==========================================
    // Address decode
    function automatic logic hit(input logic [`FSK_ADDR_W-1:0] a,
                                 input logic [`FSK_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    assign run    = (st.phase == fsk_pkg::FSK_PH_RUN);
    assign win    = st.config_r[`FSK_CFG_KEYWIN_BIT];
    assign is_key = (ADDR[`FSK_ADDR_W-1:3] == 2'(`FSK_KEY_BASE >> 3));

    // Key bytes only from RAM code, never from the debug path
    assign key_wr  = run && WR && is_key && win && RAM_EXEC && !DBG_ACCESS;
    // Reopening the window restarts entry, so a spoiled key can be tried again
    assign key_clr = run && WR && hit(ADDR, `FSK_OFS_CONFIG)
                     && WDATA[`FSK_CFG_KEYWIN_BIT] && !win;
    assign div_wr  = run && WR && hit(ADDR, `FSK_OFS_CLKDIV);

    // ==========================================
    // Sub-blocks
    fsk_key_entry #(
        .KEY_BYTES  (`FSK_KEY_BYTES)
    ) u_key (
        .clk        (CLK),
        .reset_n    (RESET_N),
        .clr        (key_clr),
        .wr         (key_wr),
        .idx        (ADDR[2:0]),
        .data       (WDATA),
        .stored_key (NV_KEY),
        .match      (key_match),
        .count      (key_count)
    );

    fsk_clk_div u_div (
        .clk        (CLK),
        .reset_n    (RESET_N),
        .wr         (div_wr),
        .wdata      (WDATA[6:0]),
        .reg_value  (div_reg),
        .done       (div_done)
    );

    // ==========================================
    // Control and status
    always_comb begin
        next_st        = st;
        next_st.cmd_go = 1'b0;
        next_st.rdata  = `FSK_RESET_BYTE;
        case (st.phase)
            fsk_pkg::FSK_PH_LOAD: begin
                // Copies taken one edge after reset release, not under reset
                next_st.option  = NV_OPTION;
                next_st.protect = NV_PROTECT;
                next_st.trim    = NV_TRIM;
                next_st.sec     = NV_OPTION[1:0];
                next_st.phase   = fsk_pkg::FSK_PH_RUN;
            end
            fsk_pkg::FSK_PH_RUN: begin
                if (WR && hit(ADDR, `FSK_OFS_CONFIG)) begin
                    next_st.config_r = WDATA;
                    // Window closing: compare the entered key
                    if (win && !WDATA[`FSK_CFG_KEYWIN_BIT]) begin
                        if (key_match) begin
                            next_st.sec = `FSK_SEC_UNSECURED;
                        end else begin
                            next_st.key_err = 1'b1;
                        end
                    end
                end
                // Application writes never reach protection
                if (WR && hit(ADDR, `FSK_OFS_PROTECT) && DBG_ACCESS) begin
                    next_st.protect = WDATA;
                end
                if (WR && hit(ADDR, `FSK_OFS_STATUS)) begin
                    if (WDATA[`FSK_STAT_ACCERR_BIT]) next_st.acc_err = 1'b0;
                    if (WDATA[`FSK_STAT_KEYERR_BIT]) next_st.key_err = 1'b0;
                end
                if (WR && hit(ADDR, `FSK_OFS_COMMAND)) begin
                    next_st.command = WDATA;
                    if (!div_done) begin
                        next_st.acc_err = 1'b1;
                    end else if ((WDATA == `FSK_CMD_MASS_ERASE
                                  || (WDATA == `FSK_CMD_PROGRAM && VEC_TARGET))
                                 && st.protect[`FSK_PROT_VEC_BIT]) begin
                        next_st.acc_err = 1'b1;
                    end else begin
                        next_st.cmd_go     = 1'b1;
                        next_st.blank_pend = (WDATA == `FSK_CMD_BLANK)
                                             && st.protect == `FSK_PROT_NONE;
                    end
                end
                // An access error event wins over a clear in the same cycle; a key error clear wins
                if (FLASH_DONE) begin
                    next_st.blank_ok = FLASH_BLANK;
                    if (st.blank_pend && FLASH_BLANK) begin
                        next_st.sec = `FSK_SEC_UNSECURED;
                    end
                    next_st.blank_pend = 1'b0;
                end
                // Unsecured state holds until the next reset
                if (st.sec == `FSK_SEC_UNSECURED) next_st.sec = `FSK_SEC_UNSECURED;
                if (RD) begin
                    case (ADDR)
                        `FSK_OFS_CLKDIV:  next_st.rdata = div_reg;
                        `FSK_OFS_OPTION:  next_st.rdata = {st.option[7:2], st.sec};
                        `FSK_OFS_TRIM:    next_st.rdata = st.trim;
                        `FSK_OFS_CONFIG:  next_st.rdata = st.config_r;
                        `FSK_OFS_PROTECT: next_st.rdata = st.protect;
                        `FSK_OFS_STATUS:  next_st.rdata = {3'h0, st.acc_err, st.key_err,
                                                           st.blank_ok, st.sec};
                        `FSK_OFS_COMMAND: next_st.rdata = st.command;
                        default:          next_st.rdata = `FSK_RESET_BYTE;
                    endcase
                end
            end
            default: next_st.phase = fsk_pkg::FSK_PH_LOAD;
        endcase
        next_st.secured = (next_st.sec != `FSK_SEC_UNSECURED);
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st         <= '0;
            st.secured <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================
    // Outputs
    // Read data stands for one cycle only; the bus never waits
    assign RDATA          = st.rdata;
    assign SECURED        = st.secured;
    assign ARRAY_RD_BLOCK = st.config_r[`FSK_CFG_KEYWIN_BIT];
    assign CMD_START      = st.cmd_go;
    assign CMD_CODE       = st.command;
    assign DIV_VALUE      = div_reg[6:0];

    // ==========================================
    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // Engine timing is the engine's concern; only its answers are checked here

    AST_BACKDOOR_UNSEC: assert property (
        run && WR && hit(ADDR, `FSK_OFS_CONFIG) && win
        && !WDATA[`FSK_CFG_KEYWIN_BIT] && key_match |=> !SECURED ##1 !SECURED)
        else $error("matching key did not unsecure");

    AST_MISMATCH_KEEP: assert property (
        run && WR && hit(ADDR, `FSK_OFS_CONFIG) && win && !WDATA[`FSK_CFG_KEYWIN_BIT]
        && !key_match && !FLASH_DONE |=> $stable(st.sec) && st.key_err)
        else $error("wrong key changed security");

    AST_UNSEC_STICKY: assert property (
        run && !SECURED |=> !SECURED)
        else $error("device returned to secure mode");

    AST_WINDOW_BLOCKS: assert property (
        run && WR && hit(ADDR, `FSK_OFS_CONFIG) && WDATA[`FSK_CFG_KEYWIN_BIT]
        |=> ARRAY_RD_BLOCK)
        else $error("array reads not blocked");

    AST_KEY_RAM_ONLY: assert property (
        WR && is_key && (!RAM_EXEC || DBG_ACCESS) && !key_clr |=> $stable(key_count))
        else $error("key byte taken from non-RAM source");

    AST_PROT_APP: assert property (
        run && WR && hit(ADDR, `FSK_OFS_PROTECT) && !DBG_ACCESS |=> $stable(st.protect))
        else $error("application changed protection");

    AST_CMD_NEED_DIV: assert property (
        run && WR && hit(ADDR, `FSK_OFS_COMMAND) && !div_done
        |=> !CMD_START && st.acc_err)
        else $error("command ran without divider");

    AST_BLANK_UNSEC: assert property (
        run && FLASH_DONE && FLASH_BLANK && st.blank_pend |=> !SECURED)
        else $error("blank check did not unsecure");

    AST_RESET_COPY: assert property (
        st.phase == fsk_pkg::FSK_PH_LOAD
        |=> st.option == $past(NV_OPTION) && st.protect == $past(NV_PROTECT))
        else $error("option copy missing after reset");

    AST_DIV_ONCE: assert property (
        div_done && div_wr |=> $stable(DIV_VALUE) ##1 $stable(DIV_VALUE))
        else $error("divider rewritten");

    AST_SEC_FROM_OPTION: assert property (
        st.phase == fsk_pkg::FSK_PH_LOAD
        |=> SECURED == ($past(NV_OPTION[1:0]) != `FSK_SEC_UNSECURED))
        else $error("security state not loaded from option byte");

    AST_TRIM_COPY: assert property (
        st.phase == fsk_pkg::FSK_PH_LOAD |=> st.trim == $past(NV_TRIM))
        else $error("third option copy missing after reset");

    AST_START_NEEDS_DIV: assert property (
        CMD_START |-> div_done)
        else $error("command started before divider write");

    AST_VEC_ERASE_REFUSED: assert property (
        run && WR && hit(ADDR, `FSK_OFS_COMMAND) && WDATA == `FSK_CMD_MASS_ERASE
        && st.protect[`FSK_PROT_VEC_BIT] |=> !CMD_START && st.acc_err)
        else $error("mass erase ran on protected vector block");

    AST_WINDOW_RELEASE: assert property (
        run && WR && hit(ADDR, `FSK_OFS_CONFIG) && !WDATA[`FSK_CFG_KEYWIN_BIT]
        |=> !ARRAY_RD_BLOCK)
        else $error("array reads still blocked after window close");

    AST_PROT_DBG_WRITE: assert property (
        run && WR && hit(ADDR, `FSK_OFS_PROTECT) && DBG_ACCESS
        |=> st.protect == $past(WDATA))
        else $error("debug write did not reach protection");

    AST_DIV_FIRST_WRITE: assert property (
        div_wr && !div_done |=> DIV_VALUE == $past(WDATA[6:0]) && div_reg[7])
        else $error("first divider write not taken");

    AST_KEYERR_CLEAR: assert property (
        run && WR && hit(ADDR, `FSK_OFS_STATUS) && WDATA[`FSK_STAT_KEYERR_BIT]
        |=> !st.key_err)
        else $error("key error flag not cleared");

    AST_RDATA_IDLE: assert property (
        !RD |=> RDATA == `FSK_RESET_BYTE)
        else $error("read data outside its cycle");

    // ==========================================
    // Cover points
    COV_BACKDOOR: cover property (
        run && win && WR && hit(ADDR, `FSK_OFS_CONFIG) && key_match ##1 !SECURED);
    COV_BLANK: cover property (FLASH_DONE && st.blank_pend && FLASH_BLANK);
    COV_CMD_GO: cover property (CMD_START && CMD_CODE == `FSK_CMD_PROGRAM);
    COV_KEY_BAD: cover property (st.key_err);
    COV_KEY_RESTART: cover property (key_clr ##1 key_count == 4'h0);

endmodule : fsk_flash_security

/* File: rtl/fsk_cfg.svh */
// Offsets, field positions, reset values and command codes of the flash security block
`ifndef FSK_CFG_SVH
`define FSK_CFG_SVH

// ==========================================
// Register offsets
`define FSK_ADDR_W          5
`define FSK_OFS_CLKDIV      5'h00
`define FSK_OFS_OPTION      5'h01
`define FSK_OFS_TRIM        5'h02
`define FSK_OFS_CONFIG      5'h03
`define FSK_OFS_PROTECT     5'h04
`define FSK_OFS_STATUS      5'h05
`define FSK_OFS_COMMAND     5'h06
`define FSK_OFS_SPARE0      5'h07
`define FSK_OFS_SPARE1      5'h08
`define FSK_KEY_BASE        5'h10
`define FSK_KEY_BYTES       8

// ==========================================
// Fields and values
`define FSK_CFG_KEYWIN_BIT  5
`define FSK_SEC_UNSECURED   2'b10
`define FSK_PROT_VEC_BIT    7
`define FSK_PROT_NONE       8'h00
`define FSK_STAT_ACCERR_BIT 4
`define FSK_STAT_KEYERR_BIT 3
`define FSK_STAT_BLANK_BIT  2
`define FSK_DIV_DONE_BIT    7
`define FSK_RESET_BYTE      8'h00

// ==========================================
// Command codes
`define FSK_CMD_BLANK       8'h05
`define FSK_CMD_PROGRAM     8'h20
`define FSK_CMD_MASS_ERASE  8'h41

`endif

/* File: rtl/fsk_pkg.sv */
// Types shared by the flash security modules
package fsk_pkg;

    typedef enum logic { FSK_PH_LOAD, FSK_PH_RUN } fsk_phase_t;

    typedef struct packed {
        fsk_phase_t  phase;
        logic [1:0]  sec;
        logic        secured;
        logic [7:0]  option;
        logic [7:0]  trim;
        logic [7:0]  config_r;
        logic [7:0]  protect;
        logic        acc_err;
        logic        key_err;
        logic        blank_ok;
        logic        blank_pend;
        logic [7:0]  command;
        logic        cmd_go;
        logic [7:0]  rdata;
    } fsk_state_t;

    typedef struct packed {
        logic [7:0][7:0] bytes;
        logic [3:0]      count;
        logic            bad;
    } fsk_key_state_t;

    typedef struct packed {
        logic       done;
        logic [6:0] value;
    } fsk_div_state_t;

endpackage : fsk_pkg

/* File: rtl/fsk_key_entry.sv */
// Backdoor key entry buffer with order check and comparison
`timescale 1ns/1ps
`include "fsk_cfg.svh"

module fsk_key_entry #(
    parameter int KEY_BYTES = `FSK_KEY_BYTES
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    // Entry side
    input  wire logic                     clr,
    input  wire logic                     wr,
    input  wire logic [2:0]               idx,
    input  wire logic [7:0]               data,
    // Comparison
    input  wire logic [KEY_BYTES*8-1:0]   stored_key,
    output logic                          match,
    output logic [3:0]                    count
);

    fsk_pkg::fsk_key_state_t st;
    fsk_pkg::fsk_key_state_t next_st;

    // ==========================================
    // Entry
    always_comb begin
        next_st = st;
        if (clr) begin
            next_st.count = 4'h0;
            next_st.bad   = 1'b0;
        end else if (wr) begin
            // Bytes must arrive in ascending order; any skip spoils the key
            if (idx != st.count[2:0] || st.count == 4'(KEY_BYTES)) begin
                next_st.bad = 1'b1;
            end else begin
                next_st.bytes[idx] = data;
                next_st.count      = st.count + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign match = !st.bad && st.count == 4'(KEY_BYTES) && st.bytes == stored_key;
    assign count = st.count;

endmodule : fsk_key_entry

/* File: rtl/fsk_clk_div.sv */
// Write-once clock divider register for the nonvolatile memory clock
`timescale 1ns/1ps
`include "fsk_cfg.svh"

module fsk_clk_div (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Write side
    input  wire logic       wr,
    input  wire logic [6:0] wdata,
    // State
    output logic [7:0]      reg_value,
    output logic            done
);

    fsk_pkg::fsk_div_state_t st;
    fsk_pkg::fsk_div_state_t next_st;

    // ==========================================
    // First write after reset sticks
    always_comb begin
        next_st = st;
        if (wr && !st.done) begin
            next_st.value = wdata;
            next_st.done  = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Status flag in the top bit is never writable
    assign reg_value = {st.done, st.value};
    assign done      = st.done;

endmodule : fsk_clk_div

/* File: test/fsk_flash_model.sv */
// Behavioural flash engine that answers the commands of the security block
`timescale 1ns/1ps
`include "fsk_cfg.svh"

module fsk_flash_model (
    // Clock
    input  wire logic       clk,
    // Command side
    input  wire logic       cmd_start,
    input  wire logic [7:0] cmd_code,
    input  wire logic [3:0] lat,
    // Answer side
    output logic            flash_done,
    output logic            flash_blank
);
    logic       erased;
    logic [7:0] code;

    // ==========================================
    // Engine
    // Array starts programmed, so a blank check fails until a mass erase
    // Blank flag is only meaningful beside done; between answers it toggles
    initial begin
        flash_done = 1'b0;
        flash_blank = 1'b0;
        erased = 1'b0;
        code = 8'h00;
        forever begin
            @(posedge clk);
            if (cmd_start === 1'b1) begin
                code = cmd_code;
                repeat (lat) @(posedge clk);
                if (code == `FSK_CMD_MASS_ERASE) begin
                    erased = 1'b1;
                end else if (code == `FSK_CMD_PROGRAM) begin
                    erased = 1'b0;
                end
                flash_done <= 1'b1;
                flash_blank <= erased;
                @(posedge clk);
                flash_done <= 1'b0;
            end else begin
                flash_blank <= ~flash_blank;
            end
        end
    end
endmodule : fsk_flash_model

/* File: test/tb_top.sv */
// Self-checking bench for the flash security block
`timescale 1ns/1ps
`include "fsk_cfg.svh"

module tb_top;
    // ==========================================
    // Signals
    logic        clk;
    logic        reset_n;
    logic [4:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic        dbg;
    logic        ram;
    logic [7:0]  nv_opt;
    logic [7:0]  nv_prot;
    logic [63:0] nv_key;
    logic        vec_tgt;
    logic        f_done;
    logic        f_blank;
    logic        c_start;
    logic [7:0]  c_code;
    logic [6:0]  div_val;
    logic        secured;
    logic        rd_block;
    logic [3:0]  lat;
    logic [7:0]  v;
    int          error_cnt;
    int          checks_done;
    int          starts;
    int          cycles;
    localparam logic [63:0] KEY = 64'h8e31_5a07_c4d2_196b;

    fsk_flash_security dut (
        .CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .DBG_ACCESS(dbg), .RAM_EXEC(ram), .NV_OPTION(nv_opt),
        .NV_PROTECT(nv_prot), .NV_TRIM(8'h5a), .NV_KEY(nv_key), .VEC_TARGET(vec_tgt),
        .FLASH_DONE(f_done), .FLASH_BLANK(f_blank), .CMD_START(c_start),
        .CMD_CODE(c_code), .DIV_VALUE(div_val), .SECURED(secured),
        .ARRAY_RD_BLOCK(rd_block));

    fsk_flash_model engine (.clk(clk), .cmd_start(c_start), .cmd_code(c_code),
        .lat(lat), .flash_done(f_done), .flash_blank(f_blank));

    // ==========================================
    // Clock, pulse count and hang guard
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (c_start === 1'b1) starts++;
        if (cycles == 6000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // ==========================================
    // Access and compare tasks
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk8

    task automatic chk1(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %b seen %b", n, e, g);
        end
    endtask : chk1

    // A gap cycle after every write keeps key bytes off adjacent cycles
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d, input logic fd,
                          input logic fr);
        addr <= a;
        wdata <= d;
        dbg <= fd;
        ram <= fr;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg

    task automatic rd_reg(input logic [4:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
        @(posedge clk);
    endtask : rd_reg

    task automatic rst(input logic [7:0] opt, input logic [7:0] prot);
        reset_n <= 1'b0;
        nv_opt <= opt;
        nv_prot <= prot;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        starts = 0;
    endtask : rst

    task automatic enter_key(input logic [63:0] k, input logic fd, input logic rev);
        int j;
        wr_reg(`FSK_OFS_CONFIG, 8'h20, 1'b0, 1'b1);
        chk1("rd_block open", 1'b1, rd_block);
        for (int i = 0; i < 8; i++) begin
            j = rev ? 7 - i : i;
            wr_reg(`FSK_KEY_BASE + j[4:0], k[8*j +: 8], fd, ~fd);
        end
        wr_reg(`FSK_OFS_CONFIG, 8'h00, 1'b0, 1'b1);
        chk1("rd_block closed", 1'b0, rd_block);
    endtask : enter_key

    task automatic wait_done();
        int n;
        n = 0;
        while (f_done !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        chk1("done seen", 1'b1, f_done);
        repeat (2) @(posedge clk);
    endtask : wait_done

    task tally_and_finish();
        if (error_cnt == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    // ==========================================
    // Scenarios
    initial begin
        reset_n = 1'b0;
        addr = 5'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        dbg = 1'b0;
        ram = 1'b0;
        nv_opt = 8'hc0;
        nv_prot = 8'h80;
        nv_key = KEY;
        vec_tgt = 1'b0;
        lat = 4'h1;
        error_cnt = 0;
        checks_done = 0;
        starts = 0;
        cycles = 0;
        rst(8'hc0, 8'h80);
        chk1("secured", 1'b1, secured);
        rd_reg(`FSK_OFS_OPTION); chk8("option", 8'hc0, v);
        rd_reg(`FSK_OFS_TRIM); chk8("trim", 8'h5a, v);
        rd_reg(`FSK_OFS_PROTECT); chk8("protect", 8'h80, v);
        rd_reg(5'h0a); chk8("unmapped", 8'h00, v);
        rd_reg(`FSK_OFS_CLKDIV); chk8("div reset", 8'h00, v);
        wr_reg(`FSK_OFS_COMMAND, `FSK_CMD_BLANK, 1'b1, 1'b0);
        chk8("starts", 8'h00, starts[7:0]);
        rd_reg(`FSK_OFS_STATUS); chk1("acc err", 1'b1, v[4]);
        wr_reg(`FSK_OFS_STATUS, 8'h18, 1'b0, 1'b0);
        wr_reg(`FSK_OFS_CLKDIV, 8'h13, 1'b0, 1'b0);
        wr_reg(`FSK_OFS_CLKDIV, 8'h7f, 1'b0, 1'b0);
        chk8("div port", 8'h13, {1'b0, div_val});
        rd_reg(`FSK_OFS_CLKDIV); chk8("divider", 8'h93, v);
        wr_reg(`FSK_OFS_PROTECT, 8'h00, 1'b0, 1'b1);
        rd_reg(`FSK_OFS_PROTECT); chk8("app protect", 8'h80, v);
        wr_reg(`FSK_OFS_COMMAND, `FSK_CMD_MASS_ERASE, 1'b0, 1'b0);
        rd_reg(`FSK_OFS_STATUS); chk1("erase refused", 1'b1, v[4]);
        wr_reg(`FSK_OFS_STATUS, 8'h18, 1'b0, 1'b0);
        vec_tgt <= 1'b1;
        wr_reg(`FSK_OFS_COMMAND, `FSK_CMD_PROGRAM, 1'b0, 1'b0);
        vec_tgt <= 1'b0;
        rd_reg(`FSK_OFS_STATUS); chk1("vec prog refused", 1'b1, v[4]);
        chk8("starts", 8'h00, starts[7:0]);
        enter_key(KEY, 1'b1, 1'b0);
        chk1("dbg key", 1'b1, secured);
        rd_reg(`FSK_OFS_STATUS); chk1("key err", 1'b1, v[3]);
        enter_key(KEY ^ 64'h0000_0100_0000_0000, 1'b0, 1'b0);
        chk1("bad key", 1'b1, secured);
        enter_key(KEY, 1'b0, 1'b1);
        chk1("reversed key", 1'b1, secured);
        enter_key(KEY, 1'b0, 1'b0);
        chk1("good key", 1'b0, secured);
        rd_reg(`FSK_OFS_OPTION); chk8("option live", 8'hc2, v);
        rst(8'h42, 8'h00);
        chk1("nv unsecured", 1'b0, secured);
        rst(8'h00, 8'h80);
        chk1("resecured", 1'b1, secured);
        wr_reg(`FSK_OFS_CLKDIV, 8'h13, 1'b1, 1'b0);
        wr_reg(`FSK_OFS_PROTECT, 8'h00, 1'b1, 1'b0);
        rd_reg(`FSK_OFS_PROTECT); chk8("dbg protect", 8'h00, v);
        lat <= 4'h6;
        wr_reg(`FSK_OFS_COMMAND, `FSK_CMD_BLANK, 1'b1, 1'b0);
        chk8("code", `FSK_CMD_BLANK, c_code);
        wait_done();
        chk1("not blank", 1'b1, secured);
        lat <= 4'h0;
        wr_reg(`FSK_OFS_COMMAND, `FSK_CMD_MASS_ERASE, 1'b1, 1'b0);
        wait_done();
        wr_reg(`FSK_OFS_COMMAND, `FSK_CMD_BLANK, 1'b1, 1'b0);
        wait_done();
        chk1("blank unsecure", 1'b0, secured);
        chk8("starts", 8'h03, starts[7:0]);
        wr_reg(`FSK_OFS_COMMAND, `FSK_CMD_PROGRAM, 1'b1, 1'b0);
        chk8("prog code", `FSK_CMD_PROGRAM, c_code);
        wait_done();
        chk1("prog keeps unsec", 1'b0, secured);
        chk8("starts", 8'h04, starts[7:0]);
        tally_and_finish();
    end
endmodule : tb_top
